// file: shared/dsas_cfg.svh
// Timing counts, register offsets and field positions for the dual-slope sequencer
`ifndef DSAS_CFG_SVH
`define DSAS_CFG_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DSAS_CLK_HZ 40000000
`define DSAS_BLANK_US 20
`define DSAS_BLANK_CYCLES ((`DSAS_BLANK_US * `DSAS_CLK_HZ + 999999) / 1000000)
`define DSAS_POR_MS 50
`define DSAS_POR_CYCLES ((`DSAS_POR_MS * `DSAS_CLK_HZ + 999) / 1000)
`define DSAS_INTEG_60_TICKS 16'h1a0a
`define DSAS_INTEG_50_TICKS 16'h1f40

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define DSAS_OFS_CTRL 4'h0
`define DSAS_OFS_STATUS 4'h4
`define DSAS_OFS_COUNT 4'h8
`define DSAS_CTRL_CONVERT 0
`define DSAS_CTRL_LINE50 1
`define DSAS_ST_INTEG 0
`define DSAS_ST_READ 1
`define DSAS_ST_POL 2
`define DSAS_ST_LOCK 3
`define DSAS_ST_AZ 4
`define DSAS_ST_POR 5
`define DSAS_RESP_OKAY 2'h0
`define DSAS_RESP_SLVERR 2'h2

`endif

// file: shared/dsas_pkg.sv
// Types shared by the dual-slope sequencer files
package dsas_pkg;
  typedef enum logic [2:0] {
    DSAS_IDLE,
    DSAS_ARMED,
    DSAS_INTEG,
    DSAS_READ,
    DSAS_DONE
  } dsas_state_t;
  typedef logic [31:0] dsas_word_t;
  typedef logic [3:0] dsas_addr_t;
  typedef logic [1:0] dsas_resp_t;
endpackage : dsas_pkg

// file: hw/dsas_sync2.sv
// Two-flop synchroniser for one pin input
`timescale 1ns/1ps
module dsas_sync2 (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic d,
  output logic q
);
  logic meta;

  // First flop feeds only the second
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : dsas_sync2

// file: hw/dsas_sequencer.sv
// Dual-slope converter timing sequencer with AXI4-Lite registers
//
// Overview of operation
// - Integrate lasts 16.666 or 20.000 ms by line.
// - Convert clears integrate, lockout; loads integrate counter.
// - First strobe after convert asserts integrate_n.
// - Later strobes decrement counter; zero gives timeout.
// - Tick after timeout ends integrate, sets lockout.
// - Timeout captures comparator, picks reference polarity.
// - Same tick ending integrate starts read.
// - Read counter counts 6 MHz clock.
// - Comparator change ends read phase.
// - Comparator ignored for first 20 us.
// - Read end sets lockout until next convert.
// - Conversion end asserts autozero_n.
// - Integrate start releases autozero_n high.
// - Power-on reset held about 50 ms.
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "dsas_cfg.svh"
module dsas_sequencer #(
  parameter int unsigned POR_CYCLES = `DSAS_POR_CYCLES,
  parameter int unsigned READ_W = 20
) (
  input wire logic clk_sys,
  input wire logic ce,
  input wire logic reset_n,
  input wire logic ale_pin,
  input wire logic clk6_pin,
  input wire logic comp_pin,
  input wire logic supply_ok_pin,
  output logic integrate_n,
  output logic autozero_n,
  output logic ref_pos,
  output logic ref_neg,
  output logic read_active,
  output logic polarity,
  output logic power_on_reset_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire dsas_pkg::dsas_addr_t s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire dsas_pkg::dsas_word_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output dsas_pkg::dsas_resp_t s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire dsas_pkg::dsas_addr_t s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output dsas_pkg::dsas_word_t s_axi_rdata,
  output dsas_pkg::dsas_resp_t s_axi_rresp
);
  import dsas_pkg::*;

  localparam int unsigned BLANK_CYCLES = `DSAS_BLANK_CYCLES;
  localparam int BLANK_W = $clog2(BLANK_CYCLES + 1);
  localparam int POR_W = $clog2(POR_CYCLES + 1);

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  logic ale_s, clk6_s, comp_s, supply_ok_s;
  logic ale_q, clk6_q;
  logic ale_tick, clk6_tick;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  dsas_sync2 u_sync_ale (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .d(ale_pin), .q(ale_s));
  dsas_sync2 u_sync_clk6 (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .d(clk6_pin), .q(clk6_s));
  dsas_sync2 u_sync_comp (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .d(comp_pin), .q(comp_s));
  dsas_sync2 u_sync_sup (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .d(supply_ok_pin),
    .q(supply_ok_s));

  // Rising edges of the strobe and of the 6 MHz clock become one-cycle ticks
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ale_q <= 1'b0;
      clk6_q <= 1'b0;
    end else if (ce) begin
      ale_q <= ale_s;
      clk6_q <= clk6_s;
    end
  end
  assign ale_tick = ale_s & ~ale_q;
  assign clk6_tick = clk6_s & ~clk6_q;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_got, w_got;
  dsas_addr_t wr_addr;
  dsas_word_t wr_data;
  logic [3:0] wr_strb;
  logic wr_fire;
  logic wr_hit;
  logic cmd_convert;
  logic line50;
  dsas_word_t rd_word;
  logic rd_hit;
  logic lockout;
  logic [READ_W-1:0] read_count;

  assign wr_fire = aw_got & w_got & ~s_axi_bvalid;
  assign wr_hit = (wr_addr == `DSAS_OFS_CTRL);

  // Address and data are taken in either order; response waits for both
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DSAS_RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      wr_addr <= 4'h0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_got <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_got <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_hit || wr_addr == `DSAS_OFS_STATUS || wr_addr == `DSAS_OFS_COUNT) ?
          `DSAS_RESP_OKAY : `DSAS_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Convert is a one-cycle command; the line bit is held by software
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd_convert <= 1'b0;
      line50 <= 1'b0;
    end else if (ce) begin
      cmd_convert <= wr_fire & wr_hit & wr_strb[0] & wr_data[`DSAS_CTRL_CONVERT];
      if (wr_fire && wr_hit && wr_strb[0]) begin
        line50 <= wr_data[`DSAS_CTRL_LINE50];
      end
    end
  end

  always_comb begin
    rd_word = 32'h0;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      `DSAS_OFS_CTRL: rd_word[`DSAS_CTRL_LINE50] = line50;
      `DSAS_OFS_STATUS: begin
        rd_word[`DSAS_ST_INTEG] = ~integrate_n;
        rd_word[`DSAS_ST_READ] = read_active;
        rd_word[`DSAS_ST_POL] = polarity;
        rd_word[`DSAS_ST_LOCK] = lockout;
        rd_word[`DSAS_ST_AZ] = ~autozero_n;
        rd_word[`DSAS_ST_POR] = power_on_reset_n;
      end
      `DSAS_OFS_COUNT: rd_word[READ_W-1:0] = read_count;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `DSAS_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `DSAS_RESP_OKAY : `DSAS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Integrate timer and read timer
  // ----------------------------------------------------------------
  dsas_state_t state;
  logic [15:0] integ_cnt;
  logic timeout;
  logic integ_end;
  logic [BLANK_W-1:0] blank_cnt;
  logic zero_cross;

  assign timeout = (integ_cnt == 16'h0);
  assign integ_end = (state == DSAS_INTEG) & ale_tick & timeout;
  // Glitch blanking keeps reference switching from ending the read early
  assign zero_cross = (state == DSAS_READ) & (blank_cnt == '0) & (comp_s != polarity);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= DSAS_IDLE;
      integrate_n <= 1'b1;
      read_active <= 1'b0;
      lockout <= 1'b1;
    end else if (ce) begin
      if (cmd_convert) begin
        state <= DSAS_ARMED;
        integrate_n <= 1'b1;
        read_active <= 1'b0;
        lockout <= 1'b0;
      end else begin
        unique case (state)
          DSAS_IDLE: ;
          DSAS_ARMED: if (ale_tick && !lockout) begin
            state <= DSAS_INTEG;
            integrate_n <= 1'b0;
          end
          DSAS_INTEG: if (integ_end) begin
            state <= DSAS_READ;
            integrate_n <= 1'b1;
            read_active <= 1'b1;
            lockout <= 1'b1;
          end
          DSAS_READ: if (zero_cross) begin
            state <= DSAS_DONE;
            read_active <= 1'b0;
            lockout <= 1'b1;
          end
          DSAS_DONE: ;
        endcase
      end
    end
  end

  // Line bit picks the period; counts assume 400 kHz strobe ticks
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      integ_cnt <= 16'h0;
    end else if (ce) begin
      if (cmd_convert) begin
        integ_cnt <= line50 ? `DSAS_INTEG_50_TICKS : `DSAS_INTEG_60_TICKS;
      end else if (state == DSAS_INTEG && ale_tick && !timeout) begin
        integ_cnt <= integ_cnt - 16'h1;
      end
    end
  end

  // Comparator level at timeout chooses the opposing reference
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      polarity <= 1'b0;
      ref_pos <= 1'b0;
      ref_neg <= 1'b0;
    end else if (ce) begin
      if (cmd_convert || zero_cross) begin
        ref_pos <= 1'b0;
        ref_neg <= 1'b0;
      end else if (state == DSAS_INTEG && ale_tick && integ_cnt == 16'h1) begin
        polarity <= comp_s;
      end else if (integ_end) begin
        ref_neg <= polarity;
        ref_pos <= ~polarity;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      blank_cnt <= '0;
      read_count <= '0;
    end else if (ce) begin
      if (integ_end) begin
        blank_cnt <= BLANK_W'(BLANK_CYCLES);
        read_count <= '0;
      end else if (state == DSAS_READ) begin
        if (blank_cnt != '0) begin
          blank_cnt <= blank_cnt - BLANK_W'(1);
        end
        if (clk6_tick) begin
          read_count <= read_count + READ_W'(1);
        end
      end
    end
  end

  // Autozero holds whenever no conversion runs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      autozero_n <= 1'b0;
    end else if (ce) begin
      if (cmd_convert || zero_cross) begin
        autozero_n <= 1'b0;
      end else if (state == DSAS_ARMED && ale_tick && !lockout) begin
        autozero_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power-on reset delay
  // ----------------------------------------------------------------
  logic [POR_W-1:0] por_cnt;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      por_cnt <= '0;
      power_on_reset_n <= 1'b0;
    end else if (ce) begin
      if (!supply_ok_s) begin
        por_cnt <= '0;
        power_on_reset_n <= 1'b0;
      end else if (por_cnt == POR_W'(POR_CYCLES)) begin
        power_on_reset_n <= 1'b1;
      end else begin
        por_cnt <= por_cnt + POR_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_convert_clears: assert property (ce && cmd_convert |=> state == DSAS_ARMED && !lockout)
    else $error("convert did not arm the sequencer");
  a_integ_load: assert property (ce && cmd_convert |=>
    integ_cnt == ($past(line50) ? `DSAS_INTEG_50_TICKS : `DSAS_INTEG_60_TICKS))
    else $error("integrate counter loaded with wrong count");
  a_first_tick: assert property (ce && state == DSAS_ARMED && ale_tick && !lockout
    && !cmd_convert |=> !integrate_n && autozero_n)
    else $error("first strobe did not start integrate");
  a_count_down: assert property (ce && state == DSAS_INTEG && ale_tick && !timeout
    && !cmd_convert |=> integ_cnt == $past(integ_cnt) - 16'h1)
    else $error("integrate counter did not decrement");
  a_integ_end: assert property (ce && integ_end && !cmd_convert |=>
    integrate_n && lockout && read_active && state == DSAS_READ)
    else $error("timeout tick did not hand over to read");
  a_ref_select: assert property (read_active |-> ref_neg == polarity && ref_pos == !polarity)
    else $error("reference drive does not match polarity");
  a_read_count: assert property (ce && state == DSAS_READ && clk6_tick && !cmd_convert
    |=> read_count == $past(read_count) + READ_W'(1))
    else $error("read counter missed a 6 MHz edge");
  a_blank_hold: assert property (ce && state == DSAS_READ && blank_cnt != '0 && !cmd_convert
    |=> state == DSAS_READ)
    else $error("read ended inside the blanking interval");
  a_read_end: assert property (ce && zero_cross && !cmd_convert |=>
    state == DSAS_DONE && lockout && !autozero_n && !read_active)
    else $error("comparator change did not end read");
  a_az_release: assert property (!integrate_n |-> autozero_n)
    else $error("autozero asserted during integrate");
  a_result_hold: assert property (ce && state == DSAS_DONE && !cmd_convert |=>
    $stable(read_count) && $stable(polarity))
    else $error("result changed after read end");
  a_por_low: assert property (ce && !supply_ok_s |=> !power_on_reset_n)
    else $error("power-on reset released without supply");

  c_conversion: cover property (state == DSAS_READ ##1 state == DSAS_DONE);
  c_por_release: cover property ($rose(power_on_reset_n));
  c_axi_write: cover property (s_axi_bvalid && s_axi_bready);
  c_line50: cover property (cmd_convert && line50);
endmodule : dsas_sequencer

// file: bench/dsas_ctrl_model.sv
// Controller-side model: address strobe ticks and the 6 MHz count clock
`timescale 1ns/1ps
module dsas_ctrl_model #(
  parameter int unsigned ALE_HALF = 2,
  parameter int unsigned C6_HALF = 3
) (
  input wire logic clk_sys,
  output logic ale_pin,
  output logic clk6_pin
);
  // ------------------------------------------------------------
  // Clock sources
  // ------------------------------------------------------------
  // Strobe runs far above 400 kHz so a 20 ms integrate fits a short run;
  // a larger ALE_HALF gives the slow controller
  int unsigned ale_cnt;
  int unsigned c6_cnt;
  initial begin
    ale_pin = 1'b0;
    clk6_pin = 1'b0;
    ale_cnt = 0;
    c6_cnt = 0;
  end
  always @(posedge clk_sys) begin
    ale_cnt <= (ale_cnt == ALE_HALF - 1) ? 0 : ale_cnt + 1;
    c6_cnt <= (c6_cnt == C6_HALF - 1) ? 0 : c6_cnt + 1;
    if (ale_cnt == ALE_HALF - 1) begin
      ale_pin <= ~ale_pin;
    end
    if (c6_cnt == C6_HALF - 1) begin
      clk6_pin <= ~clk6_pin;
    end
  end
endmodule : dsas_ctrl_model

// file: bench/test_dual_slope_adc_sequencer.sv
// Self-checking bench for the dual-slope converter sequencer
`timescale 1ns/1ps
`include "dsas_cfg.svh"
module test_dual_slope_adc_sequencer;
  import dsas_pkg::*;
  typedef struct {
    logic [31:0] lo;
    logic [31:0] hi;
    logic [1:0] resp;
  } dsas_exp_t;
  localparam int unsigned POR = 50;
  localparam int unsigned C6 = 6;
  logic clk_sys, reset_n, ce, comp_pin, supply_ok_pin, ale_pin, clk6_pin, ale_d;
  logic integrate_n, autozero_n, ref_pos, ref_neg, read_active, polarity, power_on_reset_n;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_wstrb;
  dsas_addr_t s_axi_awaddr, s_axi_araddr;
  dsas_word_t s_axi_wdata, s_axi_rdata;
  dsas_resp_t s_axi_bresp, s_axi_rresp;
  dsas_exp_t rq[$];
  dsas_exp_t bq[$];
  int unsigned failures, tests_run, cyc, ale_cnt;

  dsas_ctrl_model i_ctrl (.clk_sys(clk_sys), .ale_pin(ale_pin), .clk6_pin(clk6_pin));
  dsas_sequencer #(.POR_CYCLES(POR)) i_dut (
    .clk_sys(clk_sys), .ce(ce), .reset_n(reset_n), .ale_pin(ale_pin),
    .clk6_pin(clk6_pin), .comp_pin(comp_pin), .supply_ok_pin(supply_ok_pin),
    .integrate_n(integrate_n), .autozero_n(autozero_n), .ref_pos(ref_pos),
    .ref_neg(ref_neg), .read_active(read_active), .polarity(polarity),
    .power_on_reset_n(power_on_reset_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp)
  );

  // ------------------------------------------------------------
  // Clock, tick counting, timeout and result monitor
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    ale_d <= ale_pin;
    if (ale_pin === 1'b1 && ale_d === 1'b0) begin
      ale_cnt <= ale_cnt + 1;
    end
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      failures++;
      test_done;
    end
  end
  // Answers are judged against the oldest note left by the bus driver
  always @(posedge clk_sys) begin
    dsas_exp_t e;
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      e = rq.pop_front();
      rng("rdata", e.lo, e.hi, s_axi_rdata);
      chk("rresp", {30'h0, e.resp}, {30'h0, s_axi_rresp});
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      e = bq.pop_front();
      chk("bresp", {30'h0, e.resp}, {30'h0, s_axi_bresp});
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rng(input string nm, input logic [31:0] lo, input logic [31:0] hi,
                     input logic [31:0] g);
    tests_run++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      failures++;
      $display("MISMATCH %s expected %h..%h seen %h", nm, lo, hi, g);
    end
  endtask : rng
  task automatic axw(input dsas_addr_t a, input dsas_word_t d, input logic [3:0] s,
                     input dsas_resp_t r);
    bit aw_ok;
    bit w_ok;
    aw_ok = 0;
    w_ok = 0;
    bq.push_back('{32'h0, 32'h0, r});
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys);
      if (s_axi_awready === 1'b1) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input dsas_addr_t a, input dsas_word_t lo, input dsas_word_t hi,
                     input dsas_resp_t r);
    rq.push_back('{lo, hi, r});
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : axr
  task automatic wint();
    int unsigned n;
    n = 0;
    while (integrate_n !== 1'b0 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wint
  // One conversion; comparator flips dly cycles into read, ab aborts mid-integrate
  task automatic conv(input logic l50, input logic cpos, input int unsigned dly, input bit ab);
    int unsigned n;
    int unsigned t;
    int unsigned lo;
    logic [31:0] rnd;
    rnd = $urandom;
    comp_pin <= cpos;
    axw(`DSAS_OFS_CTRL, {rnd[31:2], l50, 1'b1}, 4'hf, `DSAS_RESP_OKAY);
    wint();
    if (ab) begin
      repeat (200) @(posedge clk_sys);
      axw(`DSAS_OFS_CTRL, {30'h0, l50, 1'b1}, 4'hf, `DSAS_RESP_OKAY);
      // Look before the next strobe tick can restart integrate
      repeat (1) @(posedge clk_sys);
      chk("abort_integ", 1, integrate_n);
      chk("abort_az", 0, autozero_n);
      wint();
    end
    chk("az_release", 1, autozero_n);
    n = ale_cnt;
    t = 0;
    while (integrate_n === 1'b0 && t < 40000) begin
      @(posedge clk_sys);
      t++;
    end
    chk("integ_ticks", (l50 ? 8000 : 6666) + 1, ale_cnt - n);
    chk("read_start", 1, read_active);
    chk("ref_neg", cpos, ref_neg);
    chk("ref_pos", !cpos, ref_pos);
    t = 0;
    while (read_active === 1'b1 && t < 3000) begin
      @(posedge clk_sys);
      t++;
      if (t == dly) begin
        comp_pin <= !cpos;
      end
    end
    // Blanking hides an early flip, so the read then ends on the 20 us mark
    lo = (dly < 800) ? 799 : dly + 1;
    rng("read_len", lo, lo + 7, t);
    chk("az_on", 0, autozero_n);
    chk("refs_off", 0, {ref_pos, ref_neg});
    axr(`DSAS_OFS_COUNT, t / C6 - 1, t / C6 + 1, `DSAS_RESP_OKAY);
    repeat (40) @(posedge clk_sys);
    chk("lockout", 1, integrate_n);
    axr(`DSAS_OFS_STATUS, 32'h38 | (cpos << 2), 32'h38 | (cpos << 2), `DSAS_RESP_OKAY);
    chk("polarity", cpos, polarity);
  endtask : conv
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int unsigned n;
    {reset_n, comp_pin, supply_ok_pin, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    ce = 1'b1;
    {failures, tests_run, cyc, ale_cnt, ale_d} = '0;
    void'($urandom(32'h7b42));
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("por_low", 0, power_on_reset_n);
    chk("reset_pins", 2'b10, {integrate_n, autozero_n});
    ce <= 1'b0;
    supply_ok_pin <= 1'b1;
    // Frozen block must not run its power-on delay, longer than the delay itself
    repeat (60) @(posedge clk_sys);
    chk("ce_freeze", 0, power_on_reset_n);
    ce <= 1'b1;
    n = 0;
    while (power_on_reset_n !== 1'b1 && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    rng("por_delay", POR + 1, POR + 5, n);
    axr(`DSAS_OFS_STATUS, 32'h38, 32'h38, `DSAS_RESP_OKAY);
    axr(4'hc, 32'h0, 32'h0, `DSAS_RESP_SLVERR);
    axw(4'hc, $urandom, 4'hf, `DSAS_RESP_SLVERR);
    axw(`DSAS_OFS_STATUS, 32'h1, 4'hf, `DSAS_RESP_OKAY);
    axw(`DSAS_OFS_CTRL, 32'h3, 4'h0, `DSAS_RESP_OKAY);
    repeat (30) @(posedge clk_sys);
    chk("no_start", 1, integrate_n);
    conv(1'b0, 1'b1, 200, 1'b1);
    conv(1'b1, 1'b0, 900 + $urandom % 600, 1'b0);
    test_done;
  end
endmodule : test_dual_slope_adc_sequencer
